// ===== dbc_pkg.sv
// Shared constants for the dual band dynamics compressor and its controller.
package dbc_pkg;
	// ----------------------------------------------------------------
	// Word formats
	// ----------------------------------------------------------------
	localparam int CW    = 22;  // Parameter word, 2.20 format.
	localparam int FRAC  = 20;
	localparam int AW    = 24;  // Audio sample width.
	localparam int LF    = 8;   // Fraction bits of the detector level.
	localparam int LVL_W = 14;  // Level is {octave of power, fraction}.
	localparam int PA_W  = 8;
	localparam int PRAM_DEPTH = 256;
	localparam logic [CW-1:0] ONE_Q20  = 22'h100000;
	localparam logic [CW-1:0] HALF_Q20 = 22'h080000;
	// ----------------------------------------------------------------
	// Gain table: 33 entries, one step of power octave is 3 dB
	// ----------------------------------------------------------------
	localparam int TBL_ENTRIES = 33;
	localparam logic [5:0] TBL_LAST = 6'h20;
	localparam logic [5:0] TBL_LVL_OFS = 6'h10;  // Power octave of entry 0 (-87 dB).
	// ----------------------------------------------------------------
	// Parameter memory map, index 0 main, index 1 subwoofer
	// ----------------------------------------------------------------
	localparam logic [7:0] PA_TBL    [2] = '{8'h6E, 8'hA0};
	localparam logic [7:0] PA_TCONST [2] = '{8'h64, 8'h8F};
	localparam logic [7:0] PA_HOLD   [2] = '{8'h65, 8'h90};
	localparam logic [7:0] PA_REL    [2] = '{8'h66, 8'h91};
	localparam logic [7:0] PA_LOOKAHEAD = 8'h67;
	localparam logic [7:0] PA_POST0     = 8'h68;
	localparam int         POST_STAGES  = 5;
	localparam logic [7:0] PA_LEFT_W    = 8'h92;
	localparam logic [7:0] PA_RIGHT_W   = 8'h93;
	localparam logic [7:0] PA_BQ0       = 8'h94;  // b0 b1 b2 a1 a2.
	localparam int         BQ_TAPS      = 5;
	localparam logic [6:0] LA_MAX       = 7'h64;
	localparam int         LA_DEPTH     = 101;
	localparam logic [CW-1:0] TCONST_RST = 22'h000400;
	localparam logic [CW-1:0] REL_RST    = 22'h000001;
	// ----------------------------------------------------------------
	// Controller registers on AXI4-Lite
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_ADDR   = 8'h00;
	localparam logic [7:0] REG_DATA   = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_GAIN_M = 8'h0C;
	localparam logic [7:0] REG_GAIN_S = 8'h10;
	localparam int ST_REFUSED = 0;
	localparam int ST_HOLD_SHORT = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== dbc_link_if.sv
// Link between the parameter controller and the compressor core.
`timescale 1ns/10ps
interface dbc_link_if;
	logic                    param_we;    // One-cycle write strobe.
	logic [7:0]              param_addr;
	logic [dbc_pkg::CW-1:0]  param_data;
	logic [dbc_pkg::CW-1:0]  gain_main;   // Current table gains for metering.
	logic [dbc_pkg::CW-1:0]  gain_sub;

	modport dev (input param_we, input param_addr, input param_data,
		output gain_main, output gain_sub);
	modport ctrl (output param_we, output param_addr, output param_data,
		input gain_main, input gain_sub);
endinterface

// ===== dbc_core.sv
// Compressor core: main and subwoofer detectors, gain tables, look-ahead and makeup gain.
//
// Chosen here: the parameter link port and the parameter reset values.
`timescale 1ns/10ps
module dbc_core #(
	parameter int AW       = dbc_pkg::AW,
	parameter int LA_DEPTH = dbc_pkg::LA_DEPTH
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	dbc_link_if.dev                   link,
	input  wire logic                 frame_valid,
	input  wire logic signed [AW-1:0] in_left,
	input  wire logic signed [AW-1:0] in_right,
	output logic                      out_valid,
	output logic signed [AW-1:0]      out_left,
	output logic signed [AW-1:0]      out_right,
	output logic signed [AW-1:0]      out_sub
);
	localparam int CW   = dbc_pkg::CW;
	localparam int LF   = dbc_pkg::LF;
	localparam int LW   = dbc_pkg::LVL_W;
	localparam int SQ_W = 2 * AW;
	localparam int WW   = AW + CW + 3;

	// ----------------------------------------------------------------
	// Arithmetic helpers
	// ----------------------------------------------------------------
	function automatic logic signed [WW-1:0] mulw(input logic signed [AW-1:0] x,
			input logic [CW-1:0] c);
		logic signed [WW-1:0] xe;
		logic signed [WW-1:0] ce;
		xe = x;
		ce = $signed(c);
		mulw = xe * ce;
	endfunction

	// Saturation keeps overloads from wrapping into full-scale clicks.
	function automatic logic signed [AW-1:0] sat(input logic signed [WW-1:0] v);
		logic [WW-AW:0] hi;
		hi = v[WW-1:AW-1];
		if (&hi || ~|hi) begin
			sat = v[AW-1:0];
		end else begin
			sat = {v[WW-1], {(AW-1){~v[WW-1]}}};
		end
	endfunction

	function automatic logic signed [AW-1:0] sat_mul(input logic signed [AW-1:0] x,
			input logic [CW-1:0] c);
		sat_mul = sat(mulw(x, c) >>> dbc_pkg::FRAC);
	endfunction

	function automatic logic [5:0] lead1(input logic [SQ_W-1:0] v);
		lead1 = 6'h00;
		for (int i = 0; i < SQ_W; i++) begin
			if (v[i]) begin
				lead1 = 6'(i);
			end
		end
	endfunction

	function automatic logic [CW-1:0] pram_default(input int a);
		pram_default = 22'h000000;
		if ((a >= 8'(dbc_pkg::PA_TBL[0]) && a < 8'(dbc_pkg::PA_TBL[0]) + 33)
				|| (a >= 8'(dbc_pkg::PA_TBL[1]) && a < 8'(dbc_pkg::PA_TBL[1]) + 33)
				|| (a >= 8'(dbc_pkg::PA_POST0) && a < 8'(dbc_pkg::PA_POST0) + 5)
				|| a == 8'(dbc_pkg::PA_BQ0)) begin
			pram_default = dbc_pkg::ONE_Q20;
		end else if (a == 8'(dbc_pkg::PA_LEFT_W) || a == 8'(dbc_pkg::PA_RIGHT_W)) begin
			pram_default = dbc_pkg::HALF_Q20;
		end else if (a == 8'(dbc_pkg::PA_TCONST[0]) || a == 8'(dbc_pkg::PA_TCONST[1])) begin
			pram_default = dbc_pkg::TCONST_RST;
		end else if (a == 8'(dbc_pkg::PA_REL[0]) || a == 8'(dbc_pkg::PA_REL[1])) begin
			pram_default = dbc_pkg::REL_RST;
		end
	endfunction

	// ----------------------------------------------------------------
	// Parameter memory
	// ----------------------------------------------------------------
	logic [CW-1:0] pram_ff [dbc_pkg::PRAM_DEPTH];

	// Words arrive whole; the controller never splits them.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < dbc_pkg::PRAM_DEPTH; i++) begin
				pram_ff[i] <= pram_default(i);
			end
		end else if (link.param_we) begin
			pram_ff[link.param_addr] <= link.param_data;
		end
	end

	// ----------------------------------------------------------------
	// Detector inputs
	// ----------------------------------------------------------------
	logic signed [AW-1:0] det_in [2];
	logic [CW-1:0]        gain_ff [2];
	logic signed [AW:0]   lr_sum;
	logic signed [WW-1:0] wsum;
	logic signed [AW-1:0] sub_in;
	logic [CW-1:0]        bq_c [dbc_pkg::BQ_TAPS];
	logic signed [WW-1:0] bq_acc;
	logic signed [AW-1:0] bq_y;
	logic signed [AW-1:0] bx1_ff;
	logic signed [AW-1:0] bx2_ff;
	logic signed [AW-1:0] by1_ff;
	logic signed [AW-1:0] by2_ff;

	// Main detector sees the undelayed channel average.
	assign lr_sum    = AW'(0) + in_left + in_right;
	assign det_in[0] = lr_sum[AW:1];
	assign wsum      = mulw(in_left, pram_ff[dbc_pkg::PA_LEFT_W])
		+ mulw(in_right, pram_ff[dbc_pkg::PA_RIGHT_W]);
	assign sub_in    = sat(wsum >>> dbc_pkg::FRAC);
	for (genvar k = 0; k < dbc_pkg::BQ_TAPS; k++) begin : g_bqc
		assign bq_c[k] = pram_ff[8'(dbc_pkg::PA_BQ0 + k)];
	end
	assign bq_acc    = mulw(sub_in, bq_c[0]) + mulw(bx1_ff, bq_c[1])
		+ mulw(bx2_ff, bq_c[2]) - mulw(by1_ff, bq_c[3]) - mulw(by2_ff, bq_c[4]);
	assign bq_y      = sat(bq_acc >>> dbc_pkg::FRAC);
	assign det_in[1] = bq_y;

	// Biquad history moves on the frame strobe only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bx1_ff <= '0;
			bx2_ff <= '0;
			by1_ff <= '0;
			by2_ff <= '0;
		end else if (frame_valid) begin
			bx1_ff <= sub_in;
			bx2_ff <= bx1_ff;
			by1_ff <= bq_y;
			by2_ff <= by1_ff;
		end
	end

	// ----------------------------------------------------------------
	// Detectors and interpolated gain tables
	// ----------------------------------------------------------------
	for (genvar d = 0; d < 2; d++) begin : g_det
		logic [SQ_W-1:0]          ms_ff;
		logic [LW-1:0]            held_ff;
		logic [CW-1:0]            cnt_ff;
		logic [SQ_W-1:0]          sq;
		logic signed [SQ_W:0]     diff;
		logic signed [SQ_W+CW:0]  prod;
		logic signed [SQ_W+CW:0]  acc;
		logic [5:0]               oct;
		logic [SQ_W-1:0]          norm;
		logic [LW-1:0]            lvl;
		logic [CW-1:0]            rel;
		logic [LW-1:0]            rel_c;
		logic [LW:0]              dec;
		logic [LW-1:0]            nxt_held;
		logic [CW-1:0]            nxt_cnt;
		logic                     rise;
		logic [5:0]               idx_raw;
		logic [5:0]               idx;
		logic [LF-1:0]            frac;
		logic [CW-1:0]            t0;
		logic [CW-1:0]            t1;
		logic signed [CW:0]       dg;
		logic signed [CW+LF+1:0]  pr;
		logic [CW-1:0]            nxt_gain;

		// Mean-square tracker with a programmable time constant.
		assign sq   = SQ_W'(det_in[d]) * SQ_W'(det_in[d]);
		assign diff = $signed({1'b0, sq}) - $signed({1'b0, ms_ff});
		assign prod = diff * $signed(pram_ff[dbc_pkg::PA_TCONST[d]]);
		assign acc  = $signed({{(CW + 1){1'b0}}, ms_ff}) + (prod >>> dbc_pkg::FRAC);

		// One power octave is 3 dB; bits under the leading one give the fraction.
		assign oct  = lead1(ms_ff);
		assign norm = ms_ff << (6'(SQ_W - 1) - oct);
		assign lvl  = {oct, norm[SQ_W-2 -: LF]};

		// Peak riding with hold, then release toward the rms level.
		assign rel      = pram_ff[dbc_pkg::PA_REL[d]];
		assign rel_c    = (|rel[CW-1:LW]) ? {LW{1'b1}} : rel[LW-1:0];
		assign dec      = {1'b0, held_ff} - {1'b0, rel_c};
		assign rise     = lvl > held_ff;
		assign nxt_cnt  = rise ? pram_ff[dbc_pkg::PA_HOLD[d]]
			: (cnt_ff != '0) ? cnt_ff - 22'h000001 : cnt_ff;
		assign nxt_held = rise ? lvl : (cnt_ff != '0) ? held_ff
			: (dec[LW] || dec[LW-1:0] < lvl) ? lvl : dec[LW-1:0];

		// Upper bits pick the entry, lower bits walk toward the next one.
		assign idx_raw  = held_ff[LW-1:LF] - dbc_pkg::TBL_LVL_OFS;
		assign idx      = (held_ff[LW-1:LF] < dbc_pkg::TBL_LVL_OFS) ? 6'h00
			: (idx_raw >= dbc_pkg::TBL_LAST) ? dbc_pkg::TBL_LAST : idx_raw;
		assign frac     = (held_ff[LW-1:LF] < dbc_pkg::TBL_LVL_OFS
			|| idx_raw >= dbc_pkg::TBL_LAST) ? '0 : held_ff[LF-1:0];
		assign t0       = pram_ff[8'(dbc_pkg::PA_TBL[d] + idx)];
		assign t1       = (idx == dbc_pkg::TBL_LAST) ? t0
			: pram_ff[8'(dbc_pkg::PA_TBL[d] + idx + 6'h01)];
		assign dg       = $signed({t1[CW-1], t1}) - $signed({t0[CW-1], t0});
		assign pr       = dg * $signed({1'b0, frac});
		assign nxt_gain = t0 + CW'(pr >>> LF);

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ms_ff   <= '0;
				held_ff <= '0;
				cnt_ff  <= '0;
				gain_ff[d] <= dbc_pkg::ONE_Q20;
			end else if (frame_valid) begin
				ms_ff   <= acc[SQ_W-1:0];
				held_ff <= nxt_held;
				cnt_ff  <= nxt_cnt;
				gain_ff[d] <= nxt_gain;
			end
		end
	end

	assign link.gain_main = gain_ff[0];
	assign link.gain_sub  = gain_ff[1];

	// ----------------------------------------------------------------
	// Look-ahead delay on the main audio path
	// ----------------------------------------------------------------
	logic signed [AW-1:0] dly_l [LA_DEPTH];
	logic signed [AW-1:0] dly_r [LA_DEPTH];
	logic [6:0]           wr_ff;
	logic [6:0]           la;
	logic [6:0]           rd;
	logic signed [AW-1:0] del_l;
	logic signed [AW-1:0] del_r;

	// An oversized value is clamped, so a bad write cannot index past the line.
	assign la    = (|pram_ff[dbc_pkg::PA_LOOKAHEAD][CW-1:7]
		|| pram_ff[dbc_pkg::PA_LOOKAHEAD][6:0] > dbc_pkg::LA_MAX)
		? dbc_pkg::LA_MAX : pram_ff[dbc_pkg::PA_LOOKAHEAD][6:0];
	assign rd    = (wr_ff >= la) ? wr_ff - la : wr_ff + 7'(LA_DEPTH) - la;
	assign del_l = (la == '0) ? in_left : dly_l[rd];
	assign del_r = (la == '0) ? in_right : dly_r[rd];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ff <= '0;
			for (int i = 0; i < LA_DEPTH; i++) begin
				dly_l[i] <= '0;
				dly_r[i] <= '0;
			end
		end else if (frame_valid) begin
			dly_l[wr_ff] <= in_left;
			dly_r[wr_ff] <= in_right;
			wr_ff <= (wr_ff == 7'(LA_DEPTH - 1)) ? 7'h00 : wr_ff + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// Gain multipliers and makeup gain chain
	// ----------------------------------------------------------------
	logic signed [AW-1:0] pg [2][dbc_pkg::POST_STAGES + 1];

	// Each stage tops out near 6 dB, so five of them reach about 30 dB.
	assign pg[0][0] = sat_mul(del_l, gain_ff[0]);
	assign pg[1][0] = sat_mul(del_r, gain_ff[0]);
	for (genvar c = 0; c < 2; c++) begin : g_ch
		for (genvar s = 0; s < dbc_pkg::POST_STAGES; s++) begin : g_post
			assign pg[c][s+1] = sat_mul(pg[c][s], pram_ff[8'(dbc_pkg::PA_POST0 + s)]);
		end
	end

	// Outputs appear one cycle after the frame strobe.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid <= 1'b0;
			out_left  <= '0;
			out_right <= '0;
			out_sub   <= '0;
		end else begin
			out_valid <= frame_valid;
			if (frame_valid) begin
				out_left  <= pg[0][dbc_pkg::POST_STAGES];
				out_right <= pg[1][dbc_pkg::POST_STAGES];
				out_sub   <= sat_mul(sub_in, gain_ff[1]);
			end
		end
	end
endmodule

// ===== dbc_ctrl.sv
// Parameter controller: AXI4-Lite register slave that programs the compressor core.
`timescale 1ns/10ps
module dbc_ctrl (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	dbc_link_if.ctrl         link
);
	localparam int CW = dbc_pkg::CW;

	// ----------------------------------------------------------------
	// Write channel capture
	// ----------------------------------------------------------------
	logic        aw_hold_ff;
	logic [7:0]  awaddr_ff;
	logic        w_hold_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic [7:0]  paddr_ff;
	logic [CW-1:0] pdata_ff;
	logic [CW-1:0] la_sh_ff;
	logic [CW-1:0] hold_sh_ff;
	logic        refused_ff;
	logic        we_ff;
	logic        exec;
	logic [31:0] mask;
	logic [31:0] old_val;
	logic [31:0] merged;
	logic        mapped_w;
	logic        is_data;
	logic        refuse;
	logic [31:0] rd_val;
	logic        mapped_r;
	logic        clr_ref;

	function automatic logic [31:0] reg_val(input logic [7:0] a, input logic [7:0] pa,
			input logic [CW-1:0] pd, input logic [1:0] st, input logic [CW-1:0] gm,
			input logic [CW-1:0] gs);
		unique case (a)
			dbc_pkg::REG_ADDR:   reg_val = {24'h000000, pa};
			dbc_pkg::REG_DATA:   reg_val = {10'h000, pd};
			dbc_pkg::REG_STATUS: reg_val = {30'h00000000, st};
			dbc_pkg::REG_GAIN_M: reg_val = {10'h000, gm};
			dbc_pkg::REG_GAIN_S: reg_val = {10'h000, gs};
			default:             reg_val = 32'h00000000;
		endcase
	endfunction

	// Both address and data are held until the pair executes.
	assign s_axi_awready = !aw_hold_ff;
	assign s_axi_wready  = !w_hold_ff;
	assign exec     = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
	assign mask     = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	assign old_val  = reg_val(awaddr_ff, paddr_ff, pdata_ff, 2'b00, '0, '0);
	assign merged   = (old_val & ~mask) | (wdata_ff & mask);
	assign mapped_w = awaddr_ff == dbc_pkg::REG_ADDR || awaddr_ff == dbc_pkg::REG_DATA
		|| awaddr_ff == dbc_pkg::REG_STATUS || awaddr_ff == dbc_pkg::REG_GAIN_M
		|| awaddr_ff == dbc_pkg::REG_GAIN_S;
	assign is_data  = exec && awaddr_ff == dbc_pkg::REG_DATA;
	// Delays over 100 samples never reach the core; they flag instead.
	assign refuse   = is_data && paddr_ff == dbc_pkg::PA_LOOKAHEAD
		&& merged[CW-1:0] > CW'(dbc_pkg::LA_MAX);
	assign clr_ref  = exec && awaddr_ff == dbc_pkg::REG_STATUS && mask[0] && wdata_ff[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= {s_axi_awaddr[7:2], 2'b00};
			end else if (exec) begin
				aw_hold_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end else if (exec) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register state and parameter writes
	// ----------------------------------------------------------------
	// The word passes verbatim: software has already applied the time constant
	// and release encodings, the core only stores it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			paddr_ff   <= '0;
			pdata_ff   <= '0;
			la_sh_ff   <= '0;
			hold_sh_ff <= '0;
			refused_ff <= 1'b0;
			we_ff      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= dbc_pkg::RESP_OKAY;
		end else begin
			we_ff <= is_data && !refuse;
			if (exec && awaddr_ff == dbc_pkg::REG_ADDR) begin
				paddr_ff <= merged[7:0];
			end else if (is_data) begin
				paddr_ff <= paddr_ff + 8'h01;
			end
			if (is_data) begin
				pdata_ff <= merged[CW-1:0];
			end
			if (is_data && !refuse && paddr_ff == dbc_pkg::PA_LOOKAHEAD) begin
				la_sh_ff <= merged[CW-1:0];
			end
			if (is_data && paddr_ff == dbc_pkg::PA_HOLD[0]) begin
				hold_sh_ff <= merged[CW-1:0];
			end
			// A new refusal in the clearing cycle keeps the flag set.
			refused_ff <= refuse || (refused_ff && !clr_ref);
			if (exec) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped_w ? dbc_pkg::RESP_OKAY : dbc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign link.param_we   = we_ff;
	assign link.param_addr = paddr_ff - 8'h01;
	assign link.param_data = pdata_ff;

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_val   = reg_val({s_axi_araddr[7:2], 2'b00}, paddr_ff, pdata_ff,
		{hold_sh_ff < la_sh_ff, refused_ff}, link.gain_main, link.gain_sub);
	assign mapped_r = s_axi_araddr[7:2] <= dbc_pkg::REG_GAIN_S[7:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= dbc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= mapped_r ? dbc_pkg::RESP_OKAY : dbc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== dbc_link_assertions.sv
// Checker for the controller-to-core link and the audio frame timing.
`timescale 1ns/10ps
module dbc_link_assertions (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   param_we,
	input wire logic [7:0]             param_addr,
	input wire logic [dbc_pkg::CW-1:0] param_data,
	input wire logic [dbc_pkg::CW-1:0] gain_main,
	input wire logic [dbc_pkg::CW-1:0] gain_sub,
	input wire logic                   frame_valid,
	input wire logic                   out_valid,
	input wire logic signed [23:0]     out_left
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Strobes are single pulses; an over-range look-ahead word must never reach the core.
	a_we_pulse: assert property (param_we |=> !param_we) else $error("long strobe");
	a_la_limit: assert property (param_we && param_addr == dbc_pkg::PA_LOOKAHEAD |->
		param_data <= 22'h000064) else $error("look-ahead too big");
	// Every frame gives exactly one output pulse; out_left and both gains move only with frames.
	a_out_next: assert property (frame_valid |=> out_valid) else $error("no pulse");
	a_out_cause: assert property (out_valid |-> $past(frame_valid)) else $error("stray");
	a_out_hold: assert property (!out_valid |-> $stable(out_left)) else $error("moved");
	a_gm_frame: assert property (!$stable(gain_main) |-> out_valid || $past(out_valid))
		else $error("main gain moved");
	a_gs_frame: assert property (!$stable(gain_sub) |-> out_valid || $past(out_valid))
		else $error("sub gain moved");
	a_quiet_go: assert property ($rose(aresetn) |-> !out_valid && !param_we)
		else $error("busy after reset");
	c_la_write: cover property (param_we && param_addr == dbc_pkg::PA_LOOKAHEAD);
	c_frame: cover property (frame_valid ##1 out_valid);
	c_gain_move: cover property (!$stable(gain_main));
endmodule

// ===== dual_band_dynamics_compressor_tb.sv
// Self-checking bench: controller and core joined by their link.
`timescale 1ns/10ps
module dual_band_dynamics_compressor_tb;
	// ----
	// Stimulus and checks
	// ----
	localparam logic [7:0] PA = dbc_pkg::REG_ADDR, PD = dbc_pkg::REG_DATA;
	localparam logic [7:0] ST = dbc_pkg::REG_STATUS;
	logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0, fv = 1'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdata, rd;
	logic awr, wrd, bv, arr, rv, ov;
	logic [1:0] bresp, rresp, rsp;
	logic signed [23:0] il = 24'h0, ir = 24'h0, ol, orr, os;
	int err_count = 0, tests_run = 0, cyc = 0;
	dbc_link_if link ();
	dbc_ctrl dbc_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'h1),
		.link(link));
	dbc_core dbc_core_inst (.aclk(aclk), .aresetn(aresetn), .link(link), .frame_valid(fv),
		.in_left(il), .in_right(ir), .out_valid(ov), .out_left(ol), .out_right(orr),
		.out_sub(os));
	dbc_link_assertions dbc_link_assertions_inst (.aclk(aclk), .aresetn(aresetn),
		.param_we(link.param_we), .param_addr(link.param_addr), .param_data(link.param_data),
		.gain_main(link.gain_main), .gain_sub(link.gain_sub), .frame_valid(fv),
		.out_valid(ov), .out_left(ol));
	always #5 aclk = ~aclk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Ready and response are both sampled at the same edge, before the controller updates them.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'h0;
		w_done = 1'h0;
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		do begin
			@(posedge aclk);
			if (!aw_done && awr) begin
				awv <= 1'h0;
				aw_done = 1'h1;
			end
			if (!w_done && wrd) begin
				wv <= 1'h0;
				w_done = 1'h1;
			end
		end while (!bv);
		rsp = bresp;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		ara <= a;
		arv <= 1'h1;
		do @(posedge aclk); while (!arr);
		arv <= 1'h0;
		do @(posedge aclk); while (!rv);
		rd = rdata;
		rsp = rresp;
	endtask
	task automatic frm(input logic signed [23:0] l, input logic signed [23:0] r);
		fv <= 1'h1;
		il <= l;
		ir <= r;
		@(posedge aclk);
		fv <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic t_reset();
		rd_reg(dbc_pkg::REG_GAIN_M);
		chk(rd[21:0], dbc_pkg::ONE_Q20);
		rd_reg(8'h3C);
		chk(rsp, dbc_pkg::RESP_SLVERR);
		rd_reg(dbc_pkg::REG_GAIN_S);
		chk(rd[21:0], dbc_pkg::ONE_Q20);
		wr(8'h3C, 32'h0);
		chk(rsp, dbc_pkg::RESP_SLVERR);
		frm(24'h000400, 24'h000200);
		chk(ol, 24'h000400);
		chk(orr, 24'h000200);
		chk(os, 24'h000300);
	endtask
	task automatic t_refuse();
		wr(PA, 32'h67);
		wr(PD, 32'h65);
		rd_reg(ST);
		chk(rd[1:0], 32'h1);
		wr(ST, 32'h1);
		chk(rsp, dbc_pkg::RESP_OKAY);
		wr(PA, 32'h67);
		wr(PD, 32'h3);
		rd_reg(ST);
		chk(rd[1:0], 32'h2);
		wr(PA, 32'h65);
		wr(PD, 32'h3);
		rd_reg(ST);
		chk(rd[1:0], 32'h0);
	endtask
	// Zero frames flush the delay line, so only the pulse can appear three frames later.
	task automatic la_run(input logic signed [23:0] x, input logic [23:0] e);
		repeat (3) frm(24'h0, 24'h0);
		for (int k = 0; k < 4; k++) begin
			frm(k == 0 ? x : 24'h0, k == 0 ? x : 24'h0);
			if (k == 0) chk(os, x);
			chk(ol, k == 3 ? e : 24'h0);
		end
	endtask
	task automatic t_table();
		wr(PA, 32'h6E);
		wr(PD, 32'h040000);
		repeat (32) wr(PD, 32'h080000);
		wr(PA, 32'h68);
		repeat (5) wr(PD, 32'h080000);
		la_run(24'h000800, 24'h000010);
		rd_reg(dbc_pkg::REG_GAIN_M);
		chk(rd[21:0], 32'h040000);
	endtask
	// A time constant of 1.0 makes the level exact: octave 45, fraction 0x20, entry 29.
	task automatic t_interp();
		wr(PA, 8'h64);
		wr(PD, 32'h100000);
		wr(PD, 32'h3);
		wr(PD, 32'h1);
		wr(PA, 8'h8B);
		wr(PD, 32'h040000);
		wr(PD, 32'h0C0000);
		rd_reg(PA);
		chk(rd[7:0], 32'h8D);
		rd_reg(PD);
		chk(rd[21:0], 32'h0C0000);
		repeat (3) frm(24'h700000, 24'h500000);
		rd_reg(dbc_pkg::REG_GAIN_M);
		chk(rd[21:0], 32'h050000);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset();
		t_refuse();
		la_run(24'h000400, 24'h000400);
		t_table();
		t_interp();
		final_report();
	end
endmodule
